/* inc/dma_chan_pkg.sv */
/*
  Constants for the DMA channel control block: register group offsets,
  control field positions, reset values, transfer sizes and engine states.
  Assumes each channel owns one 64-byte register group on the register port.
*/
package dma_chan_pkg;

  // ****************************************************************
  // Geometry.
  // ****************************************************************
  localparam int NUM_CHAN  = 12;
  localparam int CHAN_W    = 4;
  localparam int ADDR_W    = 12;
  localparam int GRP_SHIFT = 6;

  // ****************************************************************
  // Offsets inside one channel group.
  // ****************************************************************
  localparam logic [5:0] OFS_SRC          = 6'h00;
  localparam logic [5:0] OFS_DST          = 6'h04;
  localparam logic [5:0] OFS_LEN          = 6'h08;
  localparam logic [5:0] OFS_CTRL_START   = 6'h0c;
  localparam logic [5:0] OFS_A1_CTRL      = 6'h10;
  localparam logic [5:0] OFS_A1_SRC       = 6'h14;
  localparam logic [5:0] OFS_A1_DST       = 6'h18;
  localparam logic [5:0] OFS_A1_LEN_START = 6'h1c;
  localparam logic [5:0] OFS_A2_CTRL      = 6'h20;
  localparam logic [5:0] OFS_A2_LEN       = 6'h24;
  localparam logic [5:0] OFS_A2_SRC       = 6'h28;
  localparam logic [5:0] OFS_A2_DST_START = 6'h2c;

  // ****************************************************************
  // Control word fields.
  // ****************************************************************
  localparam int F_EN       = 0;
  localparam int F_HIPRI    = 1;
  localparam int F_SIZE     = 2;
  localparam int F_SRC_INC  = 4;
  localparam int F_DST_INC  = 5;
  localparam int F_RING     = 6;
  localparam int F_RING_SEL = 10;
  localparam int F_CHAIN    = 11;
  localparam int F_QUIET    = 21;
  localparam int F_BUSY     = 24;
  localparam int CFG_W      = 15;

  localparam logic [CFG_W-1:0] CFG_RESET  = 15'h0000;
  localparam logic [31:0]      WORD_RESET = 32'h0000_0000;

  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;

  typedef enum logic [1:0] {
    XF_IDLE  = 2'b00,
    XF_READ  = 2'b01,
    XF_WRITE = 2'b10
  } xfer_t;

endpackage

/* verilog/dma_chan_ctrl.sv */
/*
  Multi-channel DMA control: per-channel pointers, lengths and control
  fields, aliased register views with start words, a two-level issue
  scheduler, chaining and a single read-then-write bus transfer engine.
  Assumes a register master per the one-cycle strobe protocol and a system
  bus that holds its ack low until each held request is served.
*/
// Contract
// - On completion a channel starts the channel named in its chain target.
// - Chain target equal to own number means no chaining.
// - Wrap select 0 wraps source addresses, 1 wraps destination addresses.
// - Nonzero wrap size n lets only the low n address bits change.
// - Wrap size zero disables wrapping.
// - Destination advances only when destination increment is set.
// - Source advances only when source increment is set.
// - Width field selects byte, halfword or word bus transfers.
// - Incrementing addresses step 1, 2 or 4 bytes matching width.
// - Preferred channels are considered first in each round.
// - After preferred channels, exactly one ordinary channel, then back.
// - Preference changes issue order only, never bus priority.
// - Enabled channel accepts triggers, goes busy and transfers.
// - Disabled channel ignores triggers, stops issuing, keeps busy.
// - Alias control words share the primary control storage.
// - Alias pointer and length views share primary storage.
// - Last word of each alias group is a start word.
// - Nonzero start write stores, reloads the counter and starts.
// - First alias group starts at 0x010 and repeats per channel.
// - Second alias group: control, length, source, destination start.
// - A nonzero start write or chain start to an enabled channel copies the reload length into the live counter.
// - Primary control-and-start word sits at 0x00c of each group.
// - Quiet mode raises an event on a zero start write.
`timescale 1ns/1ns
module dma_chan_ctrl
  import dma_chan_pkg::*;
#(
  parameter int NCH = NUM_CHAN
) (
  // Clock and reset.
  input  wire logic                clk,
  input  wire logic                rst,
  // Register port.
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [31:0]         reg_rdata,
  // System bus master.
  output logic      [31:0]         bus_addr,
  output logic      [31:0]         bus_wdata,
  output logic                     bus_rd,
  output logic                     bus_wr,
  output logic      [1:0]          bus_size,
  input  wire logic [31:0]         bus_rdata,
  input  wire logic                bus_ack,
  // Channel status.
  output logic      [NCH-1:0]      chan_busy,
  output logic      [NCH-1:0]      chain_end
);

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef struct packed {
    logic [NCH-1:0][31:0]      src;
    logic [NCH-1:0][31:0]      dst;
    logic [NCH-1:0][31:0]      reload;
    logic [NCH-1:0][31:0]      count;
    logic [NCH-1:0][CFG_W-1:0] cfg;
    logic [NCH-1:0]            quiet;
    logic [NCH-1:0]            busy;
    logic [NCH-1:0]            hp_done;
    logic [NCH-1:0]            null_ev;
    logic [CHAN_W-1:0]         cur;
    logic [CHAN_W-1:0]         lp_ptr;
    xfer_t                     st;
    logic [31:0]               rdata;
    logic [31:0]               b_addr;
    logic [31:0]               b_wdata;
    logic                      b_rd;
    logic                      b_wr;
    logic [1:0]                b_size;
  } state_t;

  state_t q;
  state_t next_q;

  logic [ADDR_W-GRP_SHIFT-1:0] ch_field;
  logic                        ch_ok;
  logic [CHAN_W-1:0]           wch;
  logic [5:0]                  ofs;
  logic [CFG_W-1:0]            cur_cfg;

  assign ch_field = reg_addr[ADDR_W-1:GRP_SHIFT];
  assign ch_ok    = int'(ch_field) < NCH;
  assign wch      = ch_field[CHAN_W-1:0];
  assign ofs      = reg_addr[GRP_SHIFT-1:0];
  assign cur_cfg  = q.cfg[q.cur];

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  function automatic logic [31:0] step_of(input logic [CFG_W-1:0] c);
    unique case (c[F_SIZE+:2])
      SZ_BYTE: step_of = 32'h1;
      SZ_HALF: step_of = 32'h2;
      default: step_of = 32'h4;
    endcase
  endfunction

  function automatic logic [31:0] ring_mask(input logic [CFG_W-1:0] c);
    ring_mask = (32'h1 << c[F_RING+:4]) - 32'h1;
  endfunction

  function automatic logic [31:0] advance(input logic [31:0]      a,
                                          input logic [CFG_W-1:0] c,
                                          input logic             wrap);
    logic [31:0] sum;
    logic [31:0] mask;
    sum  = a + step_of(c);
    mask = ring_mask(c);
    if (wrap && c[F_RING+:4] != 4'h0) begin
      advance = (a & ~mask) | (sum & mask);
    end else begin
      advance = sum;
    end
  endfunction

  function automatic logic [31:0] ctrl_view(input logic [CFG_W-1:0] c,
                                            input logic             qt,
                                            input logic             bz);
    ctrl_view = {7'h00, bz, 2'h0, qt, 6'h00, c};
  endfunction

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb begin
    logic [NCH-1:0]    start;
    logic [NCH-1:0]    rdy;
    logic              hp_any;
    logic              lp_any;
    logic [CHAN_W-1:0] hp_pick;
    logic [CHAN_W-1:0] lp_pick;
    logic [CHAN_W-1:0] pick;
    logic [CHAN_W-1:0] tgt;
    logic              trig;
    int                j;
    start   = '0;
    rdy     = '0;
    hp_any  = 1'b0;
    lp_any  = 1'b0;
    hp_pick = '0;
    lp_pick = '0;
    pick    = '0;
    tgt     = '0;
    trig    = 1'b0;
    j       = 0;
    next_q  = q;
    next_q.rdata   = WORD_RESET;
    next_q.null_ev = '0;

    // Register reads; the answer stands one cycle after the strobe.
    if (reg_rd && ch_ok) begin
      unique case (ofs)
        OFS_SRC, OFS_A1_SRC, OFS_A2_SRC: next_q.rdata = q.src[wch];
        OFS_DST, OFS_A1_DST, OFS_A2_DST_START: next_q.rdata = q.dst[wch];
        OFS_LEN, OFS_A1_LEN_START, OFS_A2_LEN: next_q.rdata = q.count[wch];
        OFS_CTRL_START, OFS_A1_CTRL, OFS_A2_CTRL: begin
          next_q.rdata = ctrl_view(q.cfg[wch], q.quiet[wch], q.busy[wch]);
        end
        default: next_q.rdata = WORD_RESET;
      endcase
    end

    // Register writes; every view lands in the one primary store.
    if (reg_wr && ch_ok) begin
      unique case (ofs)
        OFS_SRC, OFS_A1_SRC, OFS_A2_SRC: next_q.src[wch] = reg_wdata;
        OFS_DST, OFS_A1_DST, OFS_A2_DST_START: next_q.dst[wch] = reg_wdata;
        OFS_LEN, OFS_A1_LEN_START, OFS_A2_LEN: next_q.reload[wch] = reg_wdata;
        OFS_CTRL_START, OFS_A1_CTRL, OFS_A2_CTRL: begin
          next_q.cfg[wch]   = reg_wdata[CFG_W-1:0];
          next_q.quiet[wch] = reg_wdata[F_QUIET];
        end
        default: next_q.rdata = next_q.rdata;
      endcase
      trig = (ofs == OFS_CTRL_START) || (ofs == OFS_A1_LEN_START) ||
             (ofs == OFS_A2_DST_START);
    end
    if (trig && reg_wdata != WORD_RESET) begin
      start[wch] = 1'b1;
    end
    if (trig && reg_wdata == WORD_RESET && next_q.quiet[wch]) begin
      next_q.null_ev[wch] = 1'b1;
    end

    // Issue scheduling, preferred channels first, then one ordinary.
    for (int i = 0; i < NCH; i++) begin
      rdy[i] = q.cfg[i][F_EN] && q.busy[i] && q.count[i] != WORD_RESET;
    end
    for (int i = NCH - 1; i >= 0; i--) begin
      if (rdy[i] && q.cfg[i][F_HIPRI] && !q.hp_done[i]) begin
        hp_any  = 1'b1;
        hp_pick = CHAN_W'(i);
      end
    end
    for (int k = NCH; k >= 1; k--) begin
      j = int'(q.lp_ptr) + k;
      if (j >= NCH) begin
        j = j - NCH;
      end
      if (rdy[j] && !q.cfg[j][F_HIPRI]) begin
        lp_any  = 1'b1;
        lp_pick = CHAN_W'(j);
      end
    end

    // Transfer engine; the bus request carries no priority of its own.
    unique case (q.st)
      XF_IDLE: begin
        if (hp_any) begin
          pick = hp_pick;
          next_q.hp_done[hp_pick] = 1'b1;
        end else if (lp_any) begin
          pick = lp_pick;
          next_q.lp_ptr  = lp_pick;
          next_q.hp_done = '0;
        end else begin
          next_q.hp_done = '0;
        end
        if (hp_any || lp_any) begin
          next_q.cur    = pick;
          next_q.st     = XF_READ;
          next_q.b_rd   = 1'b1;
          next_q.b_addr = q.src[pick];
          next_q.b_size = q.cfg[pick][F_SIZE+:2];
        end
      end
      XF_READ: begin
        if (bus_ack) begin
          next_q.st      = XF_WRITE;
          next_q.b_rd    = 1'b0;
          next_q.b_wr    = 1'b1;
          next_q.b_wdata = bus_rdata;
          next_q.b_addr  = q.dst[q.cur];
          if (cur_cfg[F_SRC_INC]) begin
            next_q.src[q.cur] = advance(q.src[q.cur], cur_cfg,
                                        !cur_cfg[F_RING_SEL]);
          end
        end
      end
      XF_WRITE: begin
        if (bus_ack) begin
          next_q.st   = XF_IDLE;
          next_q.b_wr = 1'b0;
          if (cur_cfg[F_DST_INC]) begin
            next_q.dst[q.cur] = advance(q.dst[q.cur], cur_cfg,
                                        cur_cfg[F_RING_SEL]);
          end
          next_q.count[q.cur] = q.count[q.cur] - 32'h1;
          if (q.count[q.cur] == 32'h1) begin
            next_q.busy[q.cur] = 1'b0;
            tgt = cur_cfg[F_CHAIN+:4];
            if (tgt != q.cur && int'(tgt) < NCH) begin
              start[tgt] = 1'b1;
            end
          end
        end
      end
      default: begin
        next_q.st   = XF_IDLE;
        next_q.b_rd = 1'b0;
        next_q.b_wr = 1'b0;
      end
    endcase

    // Starts come last so that a start beats a completion in one cycle.
    for (int i = 0; i < NCH; i++) begin
      if (start[i] && next_q.cfg[i][F_EN]) begin
        next_q.count[i] = next_q.reload[i];
        next_q.busy[i]  = next_q.reload[i] != WORD_RESET;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign reg_rdata = q.rdata;
  assign bus_addr  = q.b_addr;
  assign bus_wdata = q.b_wdata;
  assign bus_rd    = q.b_rd;
  assign bus_wr    = q.b_wr;
  assign bus_size  = q.b_size;
  assign chan_busy = q.busy;
  assign chain_end = q.null_ev;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  logic [31:0] src_hi;
  assign src_hi = q.src[q.cur] & ~ring_mask(cur_cfg);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_unmapped_reads_zero: assert property (
    reg_rd && !ch_ok |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");

  a_alias_ctrl_store: assert property (
    reg_wr && ch_ok && ofs == OFS_A2_CTRL
    |=> q.cfg[$past(wch)] == $past(reg_wdata[CFG_W-1:0]))
    else $error("alias control write lost");

  a_alias_src_store: assert property (
    reg_wr && reg_addr == 12'h014 && !bus_ack |=> q.src[0] == $past(reg_wdata))
    else $error("alias source write lost");

  a_zero_start_idle: assert property (
    reg_wr && ch_ok && ofs == OFS_A1_LEN_START && reg_wdata == 32'h0 &&
    !q.busy[wch] && !bus_wr |=> !q.busy[$past(wch)])
    else $error("zero start write started channel");

  a_start_loads_len: assert property (
    reg_wr && reg_addr == 12'h01c && reg_wdata != 32'h0 && q.cfg[0][F_EN]
    |=> q.busy[0] && q.count[0] == $past(reg_wdata))
    else $error("start did not load length");

  a_read_then_write: assert property (
    bus_rd && bus_ack |=> bus_wr && !bus_rd)
    else $error("write did not follow read");

  a_ring_upper_fixed: assert property (
    bus_rd && bus_ack && cur_cfg[F_SRC_INC] && !cur_cfg[F_RING_SEL] &&
    cur_cfg[F_RING+:4] != 4'h0 && !reg_wr |=> src_hi == $past(src_hi))
    else $error("wrap changed upper source bits");

  a_fixed_dest: assert property (
    bus_wr && bus_ack && !cur_cfg[F_DST_INC] && !reg_wr
    |=> q.dst[q.cur] == $past(q.dst[q.cur]))
    else $error("fixed destination moved");

  a_source_step: assert property (
    bus_rd && bus_ack && cur_cfg[F_SRC_INC] && cur_cfg[F_RING+:4] == 4'h0 &&
    !reg_wr |=> q.src[q.cur] == $past(q.src[q.cur]) + $past(step_of(cur_cfg)))
    else $error("source step wrong");

  a_issue_enabled: assert property (
    $rose(bus_rd) && !$past(reg_wr) |-> q.cfg[q.cur][F_EN] && q.busy[q.cur])
    else $error("transfer issued for idle or disabled channel");

  a_size_from_cfg: assert property (
    $rose(bus_rd) && !$past(reg_wr) |-> bus_size == q.cfg[q.cur][F_SIZE+:2])
    else $error("transfer size differs from width field");

  a_null_event: assert property (
    reg_wr && ch_ok && ofs == OFS_A1_LEN_START && reg_wdata == 32'h0 &&
    q.quiet[wch] |=> chain_end[$past(wch)])
    else $error("zero start write raised no event");

  a_wdata_from_read: assert property (
    bus_rd && bus_ack |=> bus_wdata == $past(bus_rdata))
    else $error("written data differs from data read");

endmodule

/* tb/bus_fabric_model.sv */
/*
  Behavioural system bus fabric: answers each held read or write with a
  one-cycle ack, at once or after a stall. Assumes the engine holds its
  request and qualifiers until the edge that samples the ack.
*/
`timescale 1ns/1ns
module bus_fabric_model (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // System bus.
  input  wire logic [31:0] bus_addr,
  input  wire logic        bus_rd,
  input  wire logic        bus_wr,
  input  wire logic        slow,
  output logic      [31:0] bus_rdata,
  output logic             bus_ack
);
  logic [1:0] stall;
  // Reads return a pattern of the address; at other times the data lines toggle.
  always_ff @(posedge clk) begin
    bus_rdata <= ~bus_rdata;
    bus_ack   <= 1'b0;
    if (rst) begin
      stall     <= 2'h0;
      bus_rdata <= 32'h0000_0000;
    end else if ((bus_rd || bus_wr) && !bus_ack) begin
      stall <= stall + 2'h1;
      if (!slow || stall == 2'h3) begin
        bus_ack <= 1'b1;
        stall   <= 2'h0;
        if (bus_rd) begin
          bus_rdata <= {~bus_addr[15:0], bus_addr[15:0]};
        end
      end
    end
  end
endmodule

/* tb/dma_channel_control_aliases_tb_top.sv */
/*
  Testbench for the DMA channel control block: register tasks, a bus
  monitor and transfer scenarios. Assumes the fabric model answers the bus.
*/
`timescale 1ns/1ns
module dma_channel_control_aliases_tb_top
  import dma_chan_pkg::*;
;
  // ****************************************************************
  // Signals and helpers.
  // ****************************************************************
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic [ADDR_W-1:0]   reg_addr = '0;
  logic [31:0]         reg_wdata = '0;
  logic                reg_wr = 1'b0;
  logic                reg_rd = 1'b0;
  logic                slow = 1'b0;
  logic [31:0]         reg_rdata, bus_addr, bus_wdata, bus_rdata;
  logic                bus_rd, bus_wr, bus_ack;
  logic [1:0]          bus_size;
  logic [1:0]          cur_sz = SZ_WORD;
  logic [NUM_CHAN-1:0] chan_busy, chain_end;
  logic [31:0]         got_r[$], got_w[$], got_d[$], exp_r[$], exp_w[$];
  int                  n_fail = 0;
  int                  total_checks = 0;

  always #50 clk = ~clk;

  dma_chan_ctrl dma_chan_ctrl_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rd(bus_rd), .bus_wr(bus_wr),
    .bus_size(bus_size), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
    .chan_busy(chan_busy), .chain_end(chain_end));
  bus_fabric_model bus_fabric_model_inst (.clk(clk), .rst(rst), .bus_addr(bus_addr),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .slow(slow), .bus_rdata(bus_rdata),
    .bus_ack(bus_ack));

  function automatic logic [31:0] mk(logic en, logic [1:0] sz, logic si, logic di,
                                     logic [3:0] rg, logic rs, logic [3:0] ch);
    return 32'(en) | (32'(sz) << F_SIZE) | (32'(si) << F_SRC_INC)
         | (32'(di) << F_DST_INC) | (32'(rg) << F_RING) | (32'(rs) << F_RING_SEL)
         | (32'(ch) << F_CHAIN);
  endfunction
  function automatic logic [ADDR_W-1:0] ga(int ch, logic [5:0] o);
    return ADDR_W'(ch << GRP_SHIFT) | ADDR_W'(o);
  endfunction
  function automatic logic [31:0] adv(logic [31:0] a, int st, logic on, logic [3:0] n);
    logic [31:0] m;
    m = (n == 4'h0) ? 32'hffff_ffff : (32'h1 << n) - 32'h1;
    return on ? ((a & ~m) | ((a + 32'(st)) & m)) : a;
  endfunction

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wr(logic [ADDR_W-1:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(logic [ADDR_W-1:0] a, logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge clk);
      #1;
      if (chan_busy === '0 && bus_rd === 1'b0 && bus_wr === 1'b0) break;
    end
    if (i == 400) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task automatic check_qs();
    chk(32'(got_r.size() + got_w.size()), 32'(exp_r.size() + exp_w.size()));
    while (exp_r.size() > 0 && got_r.size() > 0 && got_w.size() > 0) begin
      chk(got_r.pop_front(), exp_r[0]);
      chk(got_d.pop_front(), {~exp_r[0][15:0], exp_r[0][15:0]});
      void'(exp_r.pop_front());
      chk(got_w.pop_front(), exp_w.pop_front());
    end
    got_r.delete();
    got_w.delete();
    got_d.delete();
    exp_r.delete();
    exp_w.delete();
  endtask
  task automatic run(int ch, logic [1:0] sz, logic si, logic di, logic [3:0] rg,
                     logic rs, logic [31:0] s, logic [31:0] d, int n);
    logic [31:0] c;
    c = mk(1'b1, sz, si, di, rg, rs, 4'(ch));
    cur_sz = sz;
    wr(ga(ch, OFS_A1_CTRL), c);
    wr(ga(ch, OFS_A1_SRC), s);
    wr(ga(ch, OFS_A1_DST), d);
    wr(ga(ch, OFS_A1_LEN_START), 32'(n));
    for (int i = 0; i < n; i++) begin
      exp_r.push_back(s);
      exp_w.push_back(d);
      s = adv(s, 1 << sz, si, rs ? 4'h0 : rg);
      d = adv(d, 1 << sz, di, rs ? rg : 4'h0);
    end
    wait_idle();
    check_qs();
    rd_chk(ga(ch, OFS_A2_SRC), s);
    rd_chk(ga(ch, OFS_A1_DST), d);
    rd_chk(ga(ch, OFS_LEN), 32'h0);
    rd_chk(ga(ch, OFS_A2_CTRL), c);
  endtask

  // Every served request is logged; reads also check the transfer size.
  always @(posedge clk) begin
    if (bus_rd && bus_ack) begin
      got_r.push_back(bus_addr);
      chk(32'(bus_size), 32'(cur_sz));
    end
    if (bus_wr && bus_ack) begin
      got_w.push_back(bus_addr);
      got_d.push_back(bus_wdata);
    end
  end

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wr(ga(1, OFS_A1_CTRL), mk(0, SZ_HALF, 1, 0, 4'h5, 1, 4'h7));
    rd_chk(ga(1, OFS_CTRL_START), mk(0, SZ_HALF, 1, 0, 4'h5, 1, 4'h7));
    rd_chk(ga(1, OFS_A2_CTRL), mk(0, SZ_HALF, 1, 0, 4'h5, 1, 4'h7));
    wr(ga(1, OFS_A1_SRC), 32'h1234_5678);
    rd_chk(ga(1, OFS_A2_SRC), 32'h1234_5678);
    wr(ga(1, OFS_A2_DST_START), 32'h0abc_def0);
    rd_chk(ga(1, OFS_A1_DST), 32'h0abc_def0);
    chk(32'(chan_busy), 32'h0);
    wr(ga(1, 6'h30), 32'hffff_ffff);
    rd_chk(ga(1, 6'h30), 32'h0);
    for (int z = 0; z < 3; z++) begin
      slow <= z[0];
      run(0, 2'(z), 1'b0, 1'b1, 4'h0, 1'b0, 32'h110, 32'h300, 3);
    end
    run(2, SZ_WORD, 1'b1, 1'b0, 4'h0, 1'b0, 32'h100, 32'h400, 2);
    run(3, SZ_WORD, 1'b1, 1'b1, 4'h3, 1'b1, 32'h104, 32'h204, 3);
    run(4, SZ_WORD, 1'b1, 1'b1, 4'h4, 1'b0, 32'h1f8, 32'h500, 3);
    run(5, SZ_HALF, 1'b1, 1'b1, 4'h0, 1'b0, 32'hffe, 32'h1ffe, 2);
    cur_sz = SZ_WORD;
    wr(ga(7, OFS_A2_CTRL), mk(1, SZ_WORD, 0, 0, 4'h0, 0, 4'h7));
    wr(ga(7, OFS_SRC), 32'h600);
    wr(ga(7, OFS_DST), 32'h700);
    wr(ga(7, OFS_A2_LEN), 32'h1);
    wr(ga(6, OFS_A1_CTRL), mk(1, SZ_WORD, 0, 0, 4'h0, 0, 4'h7));
    wr(ga(6, OFS_SRC), 32'h640);
    wr(ga(6, OFS_LEN), 32'h1);
    wr(ga(6, OFS_A2_DST_START), 32'h740);
    exp_r = {32'h640, 32'h600};
    exp_w = {32'h740, 32'h700};
    wait_idle();
    check_qs();
    wr(ga(7, OFS_CTRL_START), mk(1, SZ_WORD, 0, 0, 4'h0, 0, 4'h7));
    exp_r = {32'h600};
    exp_w = {32'h700};
    wait_idle();
    check_qs();
    wr(ga(8, OFS_A2_LEN), 32'h2);
    wr(ga(8, OFS_CTRL_START), mk(0, SZ_WORD, 0, 0, 4'h0, 0, 4'h8));
    wait_idle();
    check_qs();
    wr(ga(8, OFS_A1_CTRL), mk(1, SZ_WORD, 0, 0, 4'h0, 0, 4'h8) | (32'h1 << F_QUIET));
    wr(ga(8, OFS_A1_LEN_START), 32'h0);
    #1;
    chk(32'(chain_end), 32'h1 << 8);
    chk(32'(chan_busy), 32'h0);
    slow <= 1'b1;
    run(9, SZ_WORD, 1'b1, 1'b1, 4'h0, 1'b0, 32'h800, 32'h900, 1);
    wr(ga(9, OFS_A1_LEN_START), 32'h4);
    repeat (12) @(posedge clk);
    wr(ga(9, OFS_A2_CTRL), mk(0, SZ_WORD, 1, 1, 4'h0, 0, 4'h9));
    repeat (30) @(posedge clk);
    #1;
    chk(32'(bus_rd | bus_wr), 32'h0);
    rd_chk(ga(9, OFS_CTRL_START), mk(0, SZ_WORD, 1, 1, 4'h0, 0, 4'h9) | (32'h1 << F_BUSY));
    wr(ga(9, OFS_A2_CTRL), mk(1, SZ_WORD, 1, 1, 4'h0, 0, 4'h9));
    exp_r = {32'h804, 32'h808, 32'h80c, 32'h810};
    exp_w = {32'h904, 32'h908, 32'h90c, 32'h910};
    wait_idle();
    check_qs();
    wr(ga(11, OFS_SRC), 32'hb00);
    wr(ga(11, OFS_DST), 32'hc00);
    wr(ga(11, OFS_LEN), 32'h2);
    wr(ga(10, OFS_A1_CTRL), mk(1, SZ_WORD, 1, 1, 4'h0, 0, 4'ha));
    wr(ga(10, OFS_SRC), 32'ha00);
    wr(ga(10, OFS_DST), 32'hd00);
    wr(ga(2, OFS_SRC), 32'h2a0);
    wr(ga(10, OFS_A1_LEN_START), 32'h2);
    wr(ga(11, OFS_CTRL_START),
       mk(1, SZ_WORD, 1, 1, 4'h0, 0, 4'hb) | (32'h1 << F_HIPRI));
    wr(ga(2, OFS_A1_LEN_START), 32'h1);
    exp_r = {32'ha00, 32'hb00, 32'h2a0, 32'hb04, 32'ha04};
    exp_w = {32'hd00, 32'hc00, 32'h400, 32'hc04, 32'hd04};
    wait_idle();
    check_qs();
    report_and_stop();
  end
endmodule
